//--- pkg/csp_map.vh
/*
 Register indices, field positions, reset values and timing counts of
 the clock source select and prescaler block.
 Assumes an AXI4-Lite bus with 32-bit data; byte address is 4 x index.
*/
`ifndef CSP_MAP_VH
`define CSP_MAP_VH

// -------------------------------------------------------------------
// Register indices and address width
// -------------------------------------------------------------------
`define CSP_IDX_CLKSEL    8'h12
`define CSP_IDX_CLKOUT    8'h13
`define CSP_IDX_PRE       8'h15
`define CSP_IDX_TRIM1     8'h1b
`define CSP_IDX_TRIM2     8'h1c
`define CSP_IDX_LOWTAP    8'h20
`define CSP_ADDR_W        8

// -------------------------------------------------------------------
// Field positions and reset values
// -------------------------------------------------------------------
`define CSP_CPU_SLOW_SEL  7
`define CSP_LOW_FORCE     6
`define CSP_SYSCLK_EN     5
`define CSP_WARMUP        3
`define CSP_SLOW_PRESENT  1
`define CSP_RC_EN         0
`define CSP_SLOW_TAP_PIN  1
`define CSP_CPU_CLK_PIN   0
`define CSP_CLKSEL_RST    8'h09
`define CSP_TRIM1_RST     5'h01
`define CSP_TRIM2_RST     6'h00
`define CSP_LOWTAP_RST    3'h7

// -------------------------------------------------------------------
// Timing: aclk 25 MHz, RC nominal 8.25 MHz, trim steps in half percent
// -------------------------------------------------------------------
`define CSP_ACLK_HZ       25000000
`define CSP_RC_BASE_HZ    8250000
`define CSP_ACC_W         24
`define CSP_TRIM_UNIT     200
`define CSP_COARSE_STEP   14
`define CSP_COARSE_MID    8
`define CSP_WARMUP_CYCLES 32768

// Source codes of the glitch free multiplexers.
`define CSP_SRC_NONE      2'd0
`define CSP_SRC_RC        2'd1
`define CSP_SRC_SYS       2'd2
`define CSP_SRC_SLOW      2'd3

`endif

//--- src/csp_glitch_mux.v
/*
 Glitch free four way clock multiplexer working on clock tick pulses.
 Assumes each source is a one-cycle tick in the aclk domain; source 0
 is switched to and from without waiting for its tick.
*/
module csp_glitch_mux (
   input  wire       aclk,
   input  wire       aresetn,
   input  wire [3:0] src_tick,
   input  wire [1:0] want,
   input  wire [1:0] reset_sel,
   output reg        out_tick,
   output reg  [1:0] cur
);

   // -------------------------------------------------------------------
   // Handshake state
   // -------------------------------------------------------------------
   reg live;

   // The old source is released on its own tick, the new one is taken
   // on its own tick, so no shortened pulse ever reaches the output.
   always @(posedge aclk) begin
      if (!aresetn) begin
         cur      <= reset_sel;
         live     <= 1'b0;
         out_tick <= 1'b0;
      end else begin
         out_tick <= live & src_tick[cur];
         if (live && want != cur && (src_tick[cur] || cur == 2'd0)) begin
            live <= 1'b0;
         end else if (!live && (src_tick[want] || want == 2'd0)) begin
            live <= 1'b1;
            cur  <= want;
         end
      end
   end

endmodule

//--- src/csp_high_divider.v
/*
 Eight stage halving chain producing divide-by 1 to 128 tick taps.
 Assumes the source is a one-cycle tick in the aclk domain.
*/
module csp_high_divider (
   input  wire       aclk,
   input  wire       aresetn,
   input  wire       src_tick,
   output reg  [7:0] taps
);

   // -------------------------------------------------------------------
   // Stage counter
   // -------------------------------------------------------------------
   reg  [6:0] stage;
   wire [7:0] next_taps;

   // Each stage count advances on its source tick.
   always @(posedge aclk) begin
      if (!aresetn) begin
         stage <= 7'h00;
      end else if (src_tick) begin
         stage <= stage + 7'h01;
      end
   end

   // Tap k fires when the low k stages are all ones, one tick in 2**k.
   genvar k;
   generate
      for (k = 0; k < 8; k = k + 1) begin : g_tap
         if (k == 0) begin : g_first
            assign next_taps[k] = src_tick;
         end else begin : g_rest
            assign next_taps[k] = src_tick & (&stage[k-1:0]);
         end
      end
   endgenerate

   // Taps are registered.
   always @(posedge aclk) begin
      if (!aresetn) begin
         taps <= 8'h00;
      end else begin
         taps <= next_taps;
      end
   end

endmodule

//--- src/csp_top.v
/*
 Clock source select and prescaler block with an AXI4-Lite register file.
 Every clock is carried as a one-cycle tick in the aclk domain; the
 external system and slow clocks arrive as ticks synchronous to aclk.
*/
`include "csp_map.vh"
module csp_top #(
   parameter WARMUP_CYCLES = `CSP_WARMUP_CYCLES
) (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [31:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        system_clock_input,
   input  wire        slow_clock_input,
   input  wire        cpu_halt,
   output reg         cpu_clock_tick,
   output reg         periph_clock_tick,
   output reg  [7:0]  uart_tap_ticks,
   output reg  [3:0]  spi_tap_ticks,
   output reg  [1:0]  timer_tap_ticks,
   output reg         porta_tick,
   output reg         tap_32khz,
   output reg         low_divider_clear,
   output reg         pb2_out,
   output reg         pb2_oe,
   output reg         pb3_out,
   output reg         pb3_oe
);

   // -------------------------------------------------------------------
   // Registers and state
   // -------------------------------------------------------------------
   reg  [7:0]  clock_select_register;
   reg  [1:0]  clock_output_register;
   reg  [4:0]  rc_trim_register_one;
   reg  [5:0]  rc_trim_register_two;
   reg  [2:0]  low_tap_select;
   reg         slowclk_warmup_flag;
   reg  [15:0] warmup_count;
   reg  [23:0] rc_acc;
   reg         rc_tick;
   reg         clear_req;
   wire        cpu_slow_select = clock_select_register[`CSP_CPU_SLOW_SEL];
   wire        low_divider_source_force = clock_select_register[`CSP_LOW_FORCE];
   wire        sysclk_source_enable = clock_select_register[`CSP_SYSCLK_EN];
   wire        slowclk_present = clock_select_register[`CSP_SLOW_PRESENT];
   wire        rc_osc_enable = clock_select_register[`CSP_RC_EN];
   wire [2:0]  rc_divide_exponent = rc_trim_register_one[4:2];
   wire [3:0]  rc_coarse_trim = {rc_trim_register_one[1:0], rc_trim_register_two[5:4]};
   wire [3:0]  rc_fine_trim = rc_trim_register_two[3:0];
   wire        slow_ready = slowclk_present & ~slowclk_warmup_flag;
   wire        rc_clock = rc_tick & rc_osc_enable;
   wire [7:0]  taps;
   wire        high_src_tick;
   wire        cpu_mux_tick;
   wire        low_mux_tick;

   // -------------------------------------------------------------------
   // AXI4-Lite write channel
   // -------------------------------------------------------------------
   wire [7:0] widx = s_axi_awaddr[9:2];
   wire       wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
   wire       wr_lane = s_axi_wstrb[0];
   wire [7:0] wd = s_axi_wdata[7:0];
   wire       w_sel = (widx == `CSP_IDX_CLKSEL);
   wire       w_hit = w_sel | (widx == `CSP_IDX_CLKOUT) | (widx == `CSP_IDX_PRE)
                      | (widx == `CSP_IDX_TRIM1) | (widx == `CSP_IDX_TRIM2)
                      | (widx == `CSP_IDX_LOWTAP);
   wire       slow_rise = wr_go & wr_lane & w_sel & wd[`CSP_SLOW_PRESENT]
                          & ~slowclk_present;

   // Address and data are taken together; the response follows their handshake edge.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready         <= 1'b0;
         s_axi_wready          <= 1'b0;
         s_axi_bvalid          <= 1'b0;
         s_axi_bresp           <= 2'b00;
         clock_select_register <= `CSP_CLKSEL_RST;
         clock_output_register <= 2'b00;
         rc_trim_register_one  <= `CSP_TRIM1_RST;
         rc_trim_register_two  <= `CSP_TRIM2_RST;
         low_tap_select        <= `CSP_LOWTAP_RST;
         clear_req             <= 1'b0;
      end else begin
         s_axi_awready <= wr_go;
         s_axi_wready  <= wr_go;
         clear_req     <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         // The response is raised only once both channels have been taken.
         if (s_axi_awready) begin
            s_axi_bvalid <= 1'b1;
         end
         if (wr_go) begin
            s_axi_bresp  <= w_hit ? 2'b00 : 2'b10;
            if (wr_lane) begin
               case (widx)
                  `CSP_IDX_CLKSEL: begin
                     clock_select_register[7:5] <= wd[7:5];
                     clock_select_register[1:0] <= wd[1:0];
                  end
                  `CSP_IDX_CLKOUT: clock_output_register <= wd[1:0];
                  `CSP_IDX_PRE:    clear_req <= wd[0];
                  `CSP_IDX_TRIM1:  rc_trim_register_one <= wd[4:0];
                  `CSP_IDX_TRIM2:  rc_trim_register_two <= wd[5:0];
                  `CSP_IDX_LOWTAP: low_tap_select <= wd[2:0];
                  default: ;
               endcase
            end
         end
      end
   end

   // -------------------------------------------------------------------
   // AXI4-Lite read channel
   // -------------------------------------------------------------------
   wire [7:0] ridx = s_axi_araddr[9:2];
   wire       rd_go = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
   reg  [7:0] rd_val;
   reg        rd_hit;

   // Read data mux; the warm-up flag shows hardware state.
   always @* begin
      rd_hit = 1'b1;
      case (ridx)
         `CSP_IDX_CLKSEL: rd_val = {clock_select_register[7:5], 1'b0,
                                    slowclk_warmup_flag, 1'b0,
                                    clock_select_register[1:0]};
         `CSP_IDX_CLKOUT: rd_val = {6'h00, clock_output_register};
         `CSP_IDX_PRE:    rd_val = 8'h00;
         `CSP_IDX_TRIM1:  rd_val = {3'h0, rc_trim_register_one};
         `CSP_IDX_TRIM2:  rd_val = {2'h0, rc_trim_register_two};
         `CSP_IDX_LOWTAP: rd_val = {5'h00, low_tap_select};
         default: begin
            rd_val = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   // The read answer follows the address handshake by one cycle.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= 2'b00;
      end else begin
         s_axi_arready <= rd_go;
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         // Read data are valid only after the address has been taken.
         if (s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
         end
         if (rd_go) begin
            s_axi_rdata  <= {24'h000000, rd_val};
            s_axi_rresp  <= rd_hit ? 2'b00 : 2'b10;
         end
      end
   end

   // -------------------------------------------------------------------
   // RC oscillator model
   // -------------------------------------------------------------------
   // Trim factor in half percent units: 200 + 14*(coarse-8) + fine.
   wire [31:0] trim_factor = `CSP_TRIM_UNIT + {28'h0, rc_fine_trim}
                             + `CSP_COARSE_STEP * {28'h0, rc_coarse_trim}
                             - `CSP_COARSE_STEP * `CSP_COARSE_MID;
   wire [63:0] base_inc = (64'd1 << `CSP_ACC_W) * `CSP_RC_BASE_HZ / `CSP_ACLK_HZ;
   wire [63:0] rc_inc = (base_inc * {32'h0, trim_factor} / `CSP_TRIM_UNIT)
                        >> rc_divide_exponent;
   wire [24:0] rc_sum = {1'b0, rc_acc} + {1'b0, rc_inc[23:0]};

   // Phase accumulator; the carry is one RC clock period.
   always @(posedge aclk) begin
      if (!aresetn) begin
         rc_acc  <= 24'h000000;
         rc_tick <= 1'b0;
      end else begin
         rc_acc  <= rc_sum[23:0];
         rc_tick <= rc_sum[24];
      end
   end

   // -------------------------------------------------------------------
   // Slow clock warm-up
   // -------------------------------------------------------------------
   // Enabling the slow clock restarts warm-up; the flag clears after the count.
   always @(posedge aclk) begin
      if (!aresetn) begin
         slowclk_warmup_flag <= 1'b1;
         warmup_count        <= 16'h0000;
      end else if (slow_rise) begin
         slowclk_warmup_flag <= 1'b1;
         warmup_count        <= 16'h0000;
      end else if (slowclk_present && slowclk_warmup_flag && slow_clock_input) begin
         if ({16'h0000, warmup_count} == WARMUP_CYCLES - 1) begin
            slowclk_warmup_flag <= 1'b0;
         end
         warmup_count <= warmup_count + 16'h0001;
      end
   end

   // -------------------------------------------------------------------
   // Source selection
   // -------------------------------------------------------------------
   reg [1:0] high_want;
   reg [1:0] cpu_want;
   reg [1:0] low_want;
   reg       tap_pick;

   // Desired sources; the multiplexers move to them without glitches.
   always @* begin
      tap_pick = taps[low_tap_select];
      if (sysclk_source_enable) begin
         high_want = `CSP_SRC_SYS;
      end else if (rc_osc_enable) begin
         high_want = `CSP_SRC_RC;
      end else begin
         high_want = `CSP_SRC_NONE;
      end
      if (cpu_slow_select) begin
         cpu_want = (slow_ready && low_divider_source_force) ?
                    `CSP_SRC_SLOW : `CSP_SRC_NONE;
      end else if (high_want == `CSP_SRC_NONE) begin
         cpu_want = `CSP_SRC_SLOW;
      end else begin
         cpu_want = high_want;
      end
      if (slow_ready && (low_divider_source_force || !sysclk_source_enable)) begin
         low_want = `CSP_SRC_SLOW;
      end else begin
         low_want = `CSP_SRC_NONE;
      end
   end

   // High divider source multiplexer.
   csp_glitch_mux u_high_mux (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .src_tick  ({slow_clock_input, system_clock_input, rc_clock, 1'b0}),
      .want      (high_want),
      .reset_sel (`CSP_SRC_RC),
      .out_tick  (high_src_tick),
      .cur       ()
   );

   // Eight stage high divider.
   csp_high_divider u_high_div (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .src_tick (high_src_tick),
      .taps     (taps)
   );

   // CPU multiplexer; source 0 carries the high divider output.
   csp_glitch_mux u_cpu_mux (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .src_tick  ({slow_ready & slow_clock_input, system_clock_input,
                   rc_clock, taps[7]}),
      .want      (cpu_want),
      .reset_sel (`CSP_SRC_RC),
      .out_tick  (cpu_mux_tick),
      .cur       ()
   );

   // Low divider input multiplexer; source 0 carries the selected tap.
   csp_glitch_mux u_low_mux (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .src_tick  ({slow_ready & slow_clock_input, 2'b00, tap_pick}),
      .want      (low_want),
      .reset_sel (`CSP_SRC_NONE),
      .out_tick  (low_mux_tick),
      .cur       ()
   );

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   // All clock outputs and pins are registered.
   always @(posedge aclk) begin
      if (!aresetn) begin
         cpu_clock_tick    <= 1'b0;
         periph_clock_tick <= 1'b0;
         uart_tap_ticks    <= 8'h00;
         spi_tap_ticks     <= 4'h0;
         timer_tap_ticks   <= 2'h0;
         porta_tick        <= 1'b0;
         tap_32khz         <= 1'b0;
         low_divider_clear <= 1'b0;
         pb2_out           <= 1'b0;
         pb2_oe            <= 1'b0;
         pb3_out           <= 1'b0;
         pb3_oe            <= 1'b0;
      end else begin
         cpu_clock_tick    <= cpu_mux_tick & ~cpu_halt;
         periph_clock_tick <= taps[0];
         uart_tap_ticks    <= taps;
         spi_tap_ticks     <= {taps[4], taps[3], taps[2], taps[0]};
         timer_tap_ticks   <= {taps[2], taps[0]};
         porta_tick        <= taps[0];
         tap_32khz         <= low_mux_tick;
         low_divider_clear <= clear_req | slow_rise;
         pb2_oe            <= clock_output_register[`CSP_CPU_CLK_PIN];
         pb3_oe            <= clock_output_register[`CSP_SLOW_TAP_PIN];
         if (cpu_clock_tick) begin
            pb2_out <= ~pb2_out;
         end
         if (tap_32khz) begin
            pb3_out <= ~pb3_out;
         end
      end
   end

endmodule

//--- verif/csp_top_props.sv
/*
 Checker of the clock block ports: bus handshakes and tick routing.
 Assumes it is bound to csp_top and sees only its ports.
*/
// ----------
// Port checker
// ----------
module csp_top_props #(
   parameter WARMUP_CYCLES = 4
) (
   input wire        aclk,
   input wire        aresetn,
   input wire        s_axi_awvalid,
   input wire        s_axi_wvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire        cpu_halt,
   input wire        cpu_clock_tick,
   input wire        periph_clock_tick,
   input wire [7:0]  uart_tap_ticks,
   input wire [3:0]  spi_tap_ticks,
   input wire [1:0]  timer_tap_ticks,
   input wire        porta_tick
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Bus answers follow each accepted request by one cycle.
   a_aw_w_pair: assert property (s_axi_awready == s_axi_wready)
      else $error("awready and wready differ");
   a_aw_answer: assert property (s_axi_awready |=> s_axi_bvalid && !s_axi_awready)
      else $error("write accept not answered");
   a_w_taken: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awvalid) && $past(s_axi_wvalid))
      else $error("write answered without request");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped early");
   a_ar_answer: assert property (s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read accept not answered");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   // Clock ticks: halt silences the processor, taps reach their users.
   a_halt_stops: assert property (cpu_halt [*5] |-> !cpu_clock_tick)
      else $error("cpu tick during halt");
   a_tap_routing: assert property ({spi_tap_ticks, timer_tap_ticks, porta_tick,
      periph_clock_tick} == {uart_tap_ticks[4:2], uart_tap_ticks[0], uart_tap_ticks[2],
      {3{uart_tap_ticks[0]}}}) else $error("tap routing wrong");
endmodule

//--- verif/csp_radio_model.sv
/*
 Model of the radio chip that supplies the system and slow clock ticks.
 Assumes aclk at 25 MHz; each tick is one aclk cycle wide.
*/
module csp_radio_model #(
   parameter int SLOW_PER = 763
) (
   input  wire  aclk,
   output logic sys_tick,
   output logic slow_tick
);
   timeunit 1ns;
   timeprecision 1ps;
   int acc = 0;
   int cnt = 0;
   // System ticks at 13/25 of aclk, slow ticks near 32768 Hz.
   always @(posedge aclk) begin
      acc = acc + 13;
      sys_tick <= acc >= 25;
      if (acc >= 25)
         acc = acc - 25;
      cnt = (cnt + 1) % SLOW_PER;
      slow_tick <= cnt == 0;
   end
endmodule

//--- verif/tb_csp_top.sv
/*
 Bench of the clock block: AXI4-Lite register access and tick counts.
 Assumes csp_top, the radio model and the checker are compiled first.
*/
`include "csp_map.vh"
module tb_csp_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int N = 2000;
   localparam int S = 7630;
   logic        aclk, aresetn, cpu_halt, awvalid, wvalid, bready, arvalid, rready, p2, p3;
   logic [31:0] awaddr, wdata, araddr;
   wire         awready, wready, bvalid, arready, rvalid, sys_t, slow_t;
   wire         cpu_t, per_t, t32, pb2, pb2e, pb3, pb3e;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [7:0]  uart;
   int          error_cnt = 0, n_checks = 0, cc, cp, cs, t2, t3, cu[8];
   logic [7:0]  ra[6] = '{8'h48, 8'h4c, 8'h6c, 8'h70, 8'h80, 8'h04};
   logic [7:0]  rv[6] = '{8'h09, 8'h00, 8'h01, 8'h00, 8'h07, 8'h00};
   csp_radio_model u_radio (.aclk(aclk), .sys_tick(sys_t), .slow_tick(slow_t));
   csp_top #(.WARMUP_CYCLES(4)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .system_clock_input(sys_t), .slow_clock_input(slow_t), .cpu_halt(cpu_halt),
      .cpu_clock_tick(cpu_t), .periph_clock_tick(per_t), .uart_tap_ticks(uart),
      .spi_tap_ticks(), .timer_tap_ticks(), .porta_tick(), .tap_32khz(t32),
      .low_divider_clear(), .pb2_out(pb2), .pb2_oe(pb2e), .pb3_out(pb3), .pb3_oe(pb3e));
   // ----------
   // Tasks
   // ----------
   // Compares with an optional tolerance and counts mismatches.
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input int tol = 0);
      n_checks++;
      if (tol == 0 ? g !== e : (g + tol < e || g > e + tol)) begin
         error_cnt++;
         $display("[ERR] %0t seen %0h expected %0h", $time, g, e);
      end
   endtask
   // Writes one register; valids drop as each channel is taken.
   task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= {24'h0, a};
      wdata <= {24'h0, d};
      {awvalid, wvalid, bready} <= 3'b111;
      do begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk(bresp, er);
   endtask
   // Reads one register and compares data and response.
   task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      araddr <= {24'h0, a};
      {arvalid, rready} <= 2'b11;
      do begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      chk(rdata, e);
      chk(rresp, er);
   endtask
   // Counts ticks and pin toggles over n cycles after a settling gap.
   task automatic meas(input int n);
      repeat (20) @(posedge aclk);
      {cc, cp, cs, t2, t3} = '0;
      cu = '{default: 0};
      repeat (n) begin
         @(posedge aclk);
         cc += cpu_t;
         cp += per_t;
         cs += t32;
         t2 += (pb2 !== p2);
         t3 += (pb3 !== p3);
         p2 = pb2;
         p3 = pb3;
         for (int k = 0; k < 8; k++)
            cu[k] += uart[k];
      end
   endtask
   // Expected RC tick count in n cycles for divide, coarse and fine.
   function automatic int rc_exp(input int n, input int d, input int c, input int f);
      return int'(real'(n) * `CSP_RC_BASE_HZ * (1.0 + (c - 8) * 0.07 + f * 0.005)
         / (2 ** d) / `CSP_ACLK_HZ);
   endfunction
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ----------
   // Clock, watchdog and tests
   // ----------
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   // Ends a hung run through the same closing task.
   initial begin
      #(40 * 80000);
      error_cnt++;
      give_verdict();
   end
   // Main sequence of register accesses and tick measurements.
   initial begin
      {awaddr, wdata, araddr} = '0;
      {awvalid, wvalid, bready, arvalid, rready, cpu_halt} = '0;
      aresetn = 1'b0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (ra[i]) axr(ra[i], {24'h0, rv[i]}, i == 5 ? 2'b10 : 2'b00);
      meas(N);
      chk(cc, rc_exp(N, 0, 4, 0), 2);
      $display("reset test done");
      for (int i = 0; i < 4; i++) begin
         axw(8'h6c, {3'h0, 3'(i == 1), 2'b10}, 2'b00);
         axw(8'h70, {2'b00, 2'(i == 3), 4'(i == 2 ? 15 : 0)}, 2'b00);
         meas(N);
         chk(cp, rc_exp(N, i == 1, 8 + (i == 3), i == 2 ? 15 : 0), 2);
         chk(cp, cu[0]);
         for (int k = 1; k < 8; k++)
            chk(cu[k], cu[0] >> k, 1);
      end
      axw(8'h70, 8'h00, 2'b00);
      $display("trim test done");
      axw(8'h4c, 8'h03, 2'b00);
      meas(N);
      chk({pb2e, pb3e}, 2'b11);
      chk(t2, cc, 1);
      chk(t3, cs, 1);
      cpu_halt <= 1'b1;
      meas(N);
      chk(cc, 0);
      chk(cp, rc_exp(N, 0, 8, 0), 2);
      cpu_halt <= 1'b0;
      axw(8'h4c, 8'h00, 2'b00);
      $display("pin and halt test done");
      axw(8'h48, 8'h21, 2'b00);
      axw(8'h48, 8'h20, 2'b00);
      meas(N);
      chk(cc, N * 13 / 25, 2);
      chk(cp, N * 13 / 25, 2);
      axw(8'h48, 8'h00, 2'b00);
      meas(N);
      chk(cp, 0);
      axw(8'h48, 8'h01, 2'b00);
      meas(N);
      chk(cp, rc_exp(N, 0, 8, 0), 2);
      $display("source test done");
      axw(8'h48, 8'h03, 2'b00);
      axr(8'h48, 32'h0b, 2'b00);
      repeat (6 * 763) @(posedge aclk);
      axr(8'h48, 32'h03, 2'b00);
      axw(8'h48, 8'h43, 2'b00);
      axw(8'h48, 8'hc3, 2'b00);
      meas(S);
      chk(cc, 10, 1);
      chk(cs, 10, 1);
      chk(cp, rc_exp(S, 0, 8, 0), 3);
      axw(8'h48, 8'h83, 2'b00);
      // The CPU mux lets go of the slow clock only at its next tick.
      repeat (800) @(posedge aclk);
      meas(S);
      chk(cc, rc_exp(S, 0, 8, 0) / 128, 1);
      axw(8'h04, 8'h55, 2'b10);
      $display("slow clock test done");
      give_verdict();
   end
endmodule

bind csp_top csp_top_props #(.WARMUP_CYCLES(WARMUP_CYCLES)) u_props (.aclk, .aresetn,
   .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .cpu_halt,
   .cpu_clock_tick, .periph_clock_tick, .uart_tap_ticks, .spi_tap_ticks, .timer_tap_ticks,
   .porta_tick);
